// File: pkg/sfwe_defs.svh
// Opcodes, frame lengths, status bit positions and array limits of the
// serial flash write/erase command block.
// Assumes a 24-bit address frame and an array of 64K-byte blocks.
`ifndef SFWE_DEFS_SVH
`define SFWE_DEFS_SVH

`define SFWE_OP_BUSY_PIN_ON    8'h70
`define SFWE_OP_BUSY_PIN_OFF   8'h80
`define SFWE_OP_AUTOINC        8'had
`define SFWE_OP_BLOCK_ERASE    8'hd8
`define SFWE_OP_SECTOR_ERASE   8'h20
`define SFWE_OP_CHIP_ERASE_A   8'h60
`define SFWE_OP_CHIP_ERASE_B   8'hc7
`define SFWE_OP_SECURE_ENTER   8'hb1
`define SFWE_OP_STATUS_READ    8'h05
`define SFWE_OP_SIGNATURE      8'hab
`define SFWE_OP_LATCH_SET      8'h06
`define SFWE_OP_LATCH_CLEAR    8'h04
`define SFWE_OP_STATUS_ARM     8'h50
`define SFWE_OP_STATUS_WRITE   8'h01

`define SFWE_LEN_CMD           6'd8
`define SFWE_LEN_STATUS_WRITE  6'd16
`define SFWE_LEN_AUTOINC_NEXT  6'd24
`define SFWE_LEN_ERASE         6'd32
`define SFWE_LEN_AUTOINC_FIRST 6'd48
`define SFWE_LEN_SIG_DUMMY     6'd32
`define SFWE_LEN_MAX           6'd63

`define SFWE_SR_BUSY           0
`define SFWE_SR_LATCH          1
`define SFWE_SR_LEVEL_LO       2
`define SFWE_SR_LEVEL_HI       4
`define SFWE_SR_AUTOINC        6
`define SFWE_SR_LOCKDOWN       7

`define SFWE_BLOCKS            5'd16
`define SFWE_SECURE_TOP        24'h000fff

`endif

// File: pkg/sfwe_pkg.sv
// Types shared by the serial flash write/erase command block.
// Assumes nothing beyond a SystemVerilog compiler.
package sfwe_pkg;

    typedef enum logic [1:0] {
        SFWE_ST_IDLE = 2'b01,
        SFWE_ST_BUSY = 2'b10
    } sfwe_state_t;

    typedef enum logic [1:0] {
        SFWE_CORE_PROG   = 2'd0,
        SFWE_CORE_SECTOR = 2'd1,
        SFWE_CORE_BLOCK  = 2'd2,
        SFWE_CORE_CHIP   = 2'd3
    } sfwe_core_op_t;

endpackage : sfwe_pkg

// File: rtl/sfwe_sync.sv
// Two flip-flop level synchroniser, W bits wide.
// Assumes each bit is a slow level; multi-bit words must be quasi-static.
`timescale 1ns/1ns
module sfwe_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= RST;
            q      <= RST;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : sfwe_sync

// File: rtl/sfwe_cmd.sv
// Write/erase command interpreter of a serial flash: frame capture on the
// serial clock, command execution on mclk, requests to the array core.
// Assumes the core acknowledges each request with a one-cycle done pulse
// on mclk, and that chip select stays high for at least four mclk periods.
`timescale 1ns/1ns
`include "sfwe_defs.svh"

// Function
// - Opcode 70h turns the serial output into a ready/busy pin for auto-increment.
// - Chip select low during auto-increment programming drives busy as 0, ready as 1.
// - Opcode 80h returns the serial output to ordinary status data.
// - Bytes arrive MSB first; first byte to even, second to odd address.
// - Auto-increment stops at the top unprotected address, clearing latch and mode.
// - D8h erases the addressed 64K block unless protected.
// - 20h erases the addressed 4K sector unless protected.
// - 60h or C7h erases everything, ignored if anything is protected.
// - Program and erase start only at chip select rise after a complete command.
// - Status read works anytime except while the ready/busy pin drives the output, and repeats for seven bytes, then holds bit 0 until chip select rises.
// - Latch-set command sets the write-enable latch.
// - Latch-clear command clears the latch and leaves secure mode.
// - Arm command only takes effect when a status write follows next.
// - Status write updates only level bits and lockdown bit at chip select rise.
// - Protect pin low with lockdown set blocks writes; lockdown only sets.
// - Protect pin high or lockdown clear makes all protection bits writable.
// - B1h enters secure mode; only the 4K secure sector is programmable.
// - Status write in secure mode locks the sector; locked or programmed refuses.
// - Signature read shows mode and lock; not decoded while busy.
// - Busy bit follows the program cycle; latch clears when an erase or the last auto-increment word ends.
// - Latch-set or arm just before enables status write; success clears latch.
module sfwe_cmd
    import sfwe_pkg::*;
#(
    parameter logic [7:0] SIG_NORMAL      = 8'h5a, // Arbitrary identity value
    parameter logic [7:0] SIG_SECURE_OPEN = 8'h5b, // Arbitrary identity value
    parameter logic [7:0] SIG_SECURE_LOCK = 8'h5c  // Arbitrary identity value
) (
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic                   sck,
    input  wire logic                   ce_n,
    input  wire logic                   si,
    output logic                        so_o,
    output logic                        so_oe,
    input  wire logic                   wp_n,
    output logic                        core_req,
    output sfwe_pkg::sfwe_core_op_t     core_op,
    output logic [23:0]                 core_addr,
    output logic [15:0]                 core_data,
    output logic                        core_secure,
    input  wire logic                   core_done,
    output logic [7:0]                  status,
    output logic                        secure_mode,
    output logic                        secure_lock
);
    import sfwe_pkg::*;

    function automatic logic [4:0] prot_blocks(input logic [2:0] lvl);
        // Protection grows downward from the top block in powers of two
        if (lvl == 3'd0) prot_blocks = 5'd0;
        else if (lvl >= 3'd5) prot_blocks = `SFWE_BLOCKS;
        else prot_blocks = 5'(5'd1 << (lvl - 3'd1));
    endfunction : prot_blocks

    function automatic logic is_prot(input logic [23:0] a, input logic [2:0] lvl);
        is_prot = (a[23:20] != 4'h0) || ({1'b0, a[19:16]} >= (`SFWE_BLOCKS - prot_blocks(lvl)));
    endfunction : is_prot

    function automatic logic [23:0] top_open(input logic [2:0] lvl);
        top_open = {3'b000, 5'(`SFWE_BLOCKS - prot_blocks(lvl)), 16'h0000} - 24'd1;
    endfunction : top_open

    ////////////////////////////////////////////////////////////////////////
    // Link side, serial clock domain

    logic        first_q;
    logic        tgl_q;
    logic [5:0]  nbits_q;
    logic [7:0]  shf_q;
    logic [7:0]  byte_q [0:5];
    logic        drv_q;
    logic        so_q;
    logic [9:0]  lnk_s;
    logic [5:0]  pos;
    logic [7:0]  cur;

    assign pos = first_q ? 6'd0 : nbits_q;
    assign cur = {first_q ? 7'h00 : shf_q[6:0], si};

    // Set asynchronously while chip select is high: the next edge opens a frame
    always_ff @(posedge sck or negedge rstn or posedge ce_n) begin
        if (!rstn) first_q <= 1'b1;
        else if (ce_n) first_q <= 1'b1;
        else first_q <= 1'b0;
    end

    always_ff @(posedge sck or negedge rstn) begin
        if (!rstn) begin
            nbits_q <= 6'd0;
            shf_q   <= 8'h00;
            tgl_q   <= 1'b0;
        end else begin
            nbits_q <= (pos == `SFWE_LEN_MAX) ? `SFWE_LEN_MAX : pos + 6'd1;
            shf_q   <= cur;
            if (first_q) tgl_q <= ~tgl_q;
        end
    end

    // Byte store is left unreset; it is read only after a counted frame
    always_ff @(posedge sck) begin
        if (pos[2:0] == 3'd7 && pos[5:3] < 3'd6) begin
            byte_q[pos[5:3]] <= cur;
        end
    end

    sfwe_sync #(.W(10), .RST(10'h000)) u_sync_lnk (
        .clk  (sck),
        .rstn (rstn),
        .d    ({secure_lock, secure_mode, status}),
        .q    (lnk_s)
    );

    logic       rd_stat;
    logic       rd_sig;
    logic [7:0] sig;
    logic [7:0] obyte;

    assign rd_stat = (nbits_q >= `SFWE_LEN_CMD) && (byte_q[0] == `SFWE_OP_STATUS_READ);
    assign rd_sig  = (nbits_q >= `SFWE_LEN_SIG_DUMMY) && (byte_q[0] == `SFWE_OP_SIGNATURE)
                     && !lnk_s[`SFWE_SR_BUSY];
    assign sig     = !lnk_s[8] ? SIG_NORMAL : (lnk_s[9] ? SIG_SECURE_LOCK : SIG_SECURE_OPEN);
    assign obyte   = rd_stat ? lnk_s[7:0] : sig;

    // Output changes on the falling edge so the host samples it stable
    always_ff @(negedge sck or negedge rstn or posedge ce_n) begin
        if (!rstn) begin
            drv_q <= 1'b0;
            so_q  <= 1'b0;
        end else if (ce_n) begin
            drv_q <= 1'b0;
            so_q  <= 1'b0;
        end else begin
            drv_q <= rd_stat || rd_sig;
            so_q  <= obyte[~nbits_q[2:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command side, mclk domain

    logic [2:0]  pin_s;
    logic        ce_d_q;
    logic        seen_q;
    sfwe_state_t st_q;
    logic        latch_q;
    logic [2:0]  level_q;
    logic        lockdown_q;
    logic        autoinc_q;
    logic        busy_pin_q;
    logic        arm_q;
    logic        sec_q;
    logic        sec_lock_q;
    logic        sec_done_q;
    logic [23:0] addr_q;

    sfwe_sync #(.W(3), .RST(3'b011)) u_sync_pin (
        .clk  (mclk),
        .rstn (rstn),
        .d    ({tgl_q, wp_n, ce_n}),
        .q    (pin_s)
    );

    logic        exec;
    logic        idle;
    logic [7:0]  opc;
    logic [5:0]  nb;
    logic [23:0] a_in;
    logic        done;
    logic        ai_end;

    assign idle   = (st_q == SFWE_ST_IDLE);
    assign exec   = pin_s[0] && !ce_d_q && (pin_s[2] != seen_q);
    assign opc    = byte_q[0];
    assign nb     = nbits_q;
    assign a_in   = {byte_q[1], byte_q[2], byte_q[3]};
    assign done   = core_done && !idle;
    assign ai_end = ({addr_q[23:1], 1'b1} >= (sec_q ? `SFWE_SECURE_TOP : top_open(level_q)));

    logic          go;
    sfwe_core_op_t go_op;
    logic [23:0]   go_addr;
    logic [15:0]   go_data;
    logic          ai_first;
    logic          ai_next;
    logic          c_set;
    logic          c_clear;
    logic          c_stwr;

    always_comb begin
        go       = 1'b0;
        go_op    = SFWE_CORE_PROG;
        go_addr  = addr_q;
        go_data  = {byte_q[1], byte_q[2]};
        ai_first = 1'b0;
        ai_next  = 1'b0;
        c_set    = 1'b0;
        c_clear  = 1'b0;
        c_stwr   = 1'b0;
        if (exec) begin
            case (opc)
                `SFWE_OP_AUTOINC: begin
                    if (autoinc_q && idle && nb == `SFWE_LEN_AUTOINC_NEXT) begin
                        ai_next = 1'b1;
                        go      = 1'b1;
                    end else if (!autoinc_q && idle && latch_q && nb == `SFWE_LEN_AUTOINC_FIRST
                                 && (sec_q ? (a_in[23:12] == 12'h000 && !sec_lock_q && !sec_done_q
                                              && level_q == 3'd0)
                                           : !is_prot(a_in, level_q))) begin
                        ai_first = 1'b1;
                        go       = 1'b1;
                        go_addr  = {a_in[23:1], 1'b0};
                        go_data  = {byte_q[4], byte_q[5]};
                    end
                end
                `SFWE_OP_SECTOR_ERASE: begin
                    if (idle && latch_q && !autoinc_q && !sec_q && nb == `SFWE_LEN_ERASE
                        && !is_prot(a_in, level_q)) begin
                        go      = 1'b1;
                        go_op   = SFWE_CORE_SECTOR;
                        go_addr = {a_in[23:12], 12'h000};
                    end
                end
                `SFWE_OP_BLOCK_ERASE: begin
                    if (idle && latch_q && !autoinc_q && !sec_q && nb == `SFWE_LEN_ERASE
                        && !is_prot(a_in, level_q)) begin
                        go      = 1'b1;
                        go_op   = SFWE_CORE_BLOCK;
                        go_addr = {a_in[23:16], 16'h0000};
                    end
                end
                `SFWE_OP_CHIP_ERASE_A, `SFWE_OP_CHIP_ERASE_B: begin
                    if (idle && latch_q && !autoinc_q && !sec_q && nb == `SFWE_LEN_CMD
                        && level_q == 3'd0) begin
                        go      = 1'b1;
                        go_op   = SFWE_CORE_CHIP;
                        go_addr = 24'h000000;
                    end
                end
                `SFWE_OP_LATCH_SET: c_set = (nb == `SFWE_LEN_CMD) && idle && !autoinc_q;
                `SFWE_OP_LATCH_CLEAR: c_clear = (nb == `SFWE_LEN_CMD);
                `SFWE_OP_STATUS_WRITE: begin
                    c_stwr = arm_q && idle && !autoinc_q && nb == `SFWE_LEN_STATUS_WRITE;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ce_d_q <= 1'b1;
            seen_q <= 1'b0;
        end else begin
            ce_d_q <= pin_s[0];
            if (pin_s[0] && !ce_d_q) seen_q <= pin_s[2];
        end
    end

    // Busy runs from the accepted command until the core reports done
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) st_q <= SFWE_ST_IDLE;
        else begin
            case (st_q)
                SFWE_ST_IDLE: if (go) st_q <= SFWE_ST_BUSY;
                SFWE_ST_BUSY: if (core_done) st_q <= SFWE_ST_IDLE;
                default: st_q <= SFWE_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            core_req  <= 1'b0;
            core_op   <= SFWE_CORE_PROG;
            core_addr <= 24'h000000;
            core_data <= 16'hffff;
        end else begin
            core_req <= go;
            if (go) begin
                core_op   <= go_op;
                core_addr <= go_addr;
                core_data <= go_data;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) latch_q <= 1'b0;
        else if (c_set) latch_q <= 1'b1;
        else if (c_clear || (c_stwr && (sec_q || pin_s[1] || !lockdown_q))) latch_q <= 1'b0;
        else if (done && !autoinc_q) latch_q <= 1'b0;
        else if (done && ai_end) latch_q <= 1'b0;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            autoinc_q <= 1'b0;
            addr_q    <= 24'h000000;
        end else begin
            if (ai_first) begin
                autoinc_q <= 1'b1;
                addr_q    <= go_addr;
            end else if (c_clear) autoinc_q <= 1'b0;
            else if (done && autoinc_q) begin
                if (ai_end) autoinc_q <= 1'b0;
                else addr_q <= addr_q + 24'd2;
            end
        end
    end

    // Arm holds for one following frame only
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) arm_q <= 1'b0;
        else if (exec) arm_q <= (nb == `SFWE_LEN_CMD) && idle && !autoinc_q
                               && (opc == `SFWE_OP_STATUS_ARM || opc == `SFWE_OP_LATCH_SET);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            level_q    <= 3'd0;
            lockdown_q <= 1'b0;
        end else if (c_stwr && !sec_q) begin
            if (pin_s[1] || !lockdown_q) begin
                level_q    <= byte_q[1][`SFWE_SR_LEVEL_HI:`SFWE_SR_LEVEL_LO];
                lockdown_q <= pin_s[1] ? byte_q[1][`SFWE_SR_LOCKDOWN]
                                       : (lockdown_q | byte_q[1][`SFWE_SR_LOCKDOWN]);
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sec_q      <= 1'b0;
            sec_lock_q <= 1'b0;
            sec_done_q <= 1'b0;
        end else begin
            if (exec && opc == `SFWE_OP_SECURE_ENTER && nb == `SFWE_LEN_CMD && idle && !autoinc_q) begin
                sec_q <= 1'b1;
            end else if (c_clear) sec_q <= 1'b0;
            if (c_stwr && sec_q) sec_lock_q <= 1'b1;
            if (sec_q && autoinc_q && (c_clear || (done && ai_end))) sec_done_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) busy_pin_q <= 1'b0;
        else if (exec && nb == `SFWE_LEN_CMD && !autoinc_q) begin
            if (opc == `SFWE_OP_BUSY_PIN_ON) busy_pin_q <= 1'b1;
            else if (opc == `SFWE_OP_BUSY_PIN_OFF) busy_pin_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    logic ready_pin;

    // The ready level reaches the pin straight from chip select, no clock needed
    assign ready_pin   = busy_pin_q && autoinc_q;
    assign so_oe       = !ce_n && (ready_pin || drv_q);
    assign so_o        = ready_pin ? idle : so_q;
    assign core_secure = sec_q;
    assign secure_mode = sec_q;
    assign secure_lock = sec_lock_q;

    always_comb begin
        status                                          = 8'h00;
        status[`SFWE_SR_BUSY]                           = !idle;
        status[`SFWE_SR_LATCH]                          = latch_q;
        status[`SFWE_SR_LEVEL_HI:`SFWE_SR_LEVEL_LO]     = level_q;
        status[`SFWE_SR_AUTOINC]                        = autoinc_q;
        status[`SFWE_SR_LOCKDOWN]                       = lockdown_q;
    end

endmodule : sfwe_cmd

// File: testbench/sfwe_cmd_properties.sv
// Checker for the write/erase command block, bound to its top module.
// Assumes mclk is the only sampling clock and rstn the only reset.
`timescale 1ns/1ns
module sfwe_cmd_properties
    import sfwe_pkg::*;
(
    input wire logic                    mclk,
    input wire logic                    rstn,
    input wire logic                    ce_n,
    input wire logic                    so_oe,
    input wire logic                    wp_n,
    input wire logic                    core_req,
    input wire sfwe_pkg::sfwe_core_op_t core_op,
    input wire logic [23:0]             core_addr,
    input wire logic                    core_done,
    input wire logic [7:0]              status
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    sequence s_launch;
        core_req ##1 (status[0] && !core_req);
    endsequence
    sequence s_release;
        ##[1:2] (!status[0] && !status[1]);
    endsequence
    chk_oe_idle: assert property (ce_n |-> !so_oe)
        else $error("serial output driven while deselected");
    chk_busy_launch: assert property (core_req |-> s_launch)
        else $error("request not single or busy not raised");
    chk_req_after_cs: assert property (core_req |-> ce_n && $past(ce_n) && $past(ce_n, 2))
        else $error("request before chip select rise");
    chk_req_latch: assert property (core_req |-> $past(status[1]))
        else $error("request without write enable latch");
    chk_done_release: assert property (core_done && status[0] && !status[6] |-> s_release)
        else $error("busy or latch left set after done");
    chk_sector_base: assert property (core_req && core_op == SFWE_CORE_SECTOR |-> core_addr[11:0] == 12'h000)
        else $error("sector address not aligned");
    chk_block_base: assert property (core_req && core_op == SFWE_CORE_BLOCK |-> core_addr[15:0] == 16'h0000)
        else $error("block address not aligned");
    chk_prog_even: assert property (core_req && core_op == SFWE_CORE_PROG |-> core_addr[0] == 1'b0)
        else $error("word program address odd");
    chk_chip_open: assert property (core_req && core_op == SFWE_CORE_CHIP |-> status[4:2] == 3'h0)
        else $error("chip erase with protection set");
    chk_lock_sticky: assert property (!wp_n && $past(!wp_n, 3) && $past(!wp_n, 4) && $past(status[7])
        |-> status[7])
        else $error("lockdown cleared while protect pin low");
endmodule : sfwe_cmd_properties

bind sfwe_cmd sfwe_cmd_properties i_chk (
    .mclk(mclk), .rstn(rstn), .ce_n(ce_n), .so_oe(so_oe), .wp_n(wp_n), .core_req(core_req),
    .core_op(core_op), .core_addr(core_addr), .core_done(core_done), .status(status)
);

// File: testbench/sfwe_spi_host.sv
// SPI host model: chip select, serial clock and serial input, mode 0.
// Assumes the bench calls its tasks just after a falling edge of mclk.
`timescale 1ns/1ns
module sfwe_spi_host (
    output logic      sck,
    output logic      ce_n,
    output logic      si,
    input  wire logic so_o,
    input  wire logic so_oe
);
    initial begin
        sck = 1'b0;
        ce_n = 1'b1;
        si = 1'b0;
    end
    ////////////////////////////////////////
    // Chip select stays low over the whole frame; clock only runs inside it
    task automatic xfer(input logic [63:0] b, input int n, output logic [7:0] rd);
        rd = 8'h00;
        ce_n = 1'b0;
        #3;
        for (int i = n - 1; i >= 0; i--) begin
            si = b[i];
            #3 sck = 1'b1;
            rd = {rd[6:0], so_oe ? so_o : 1'b1}; // Released line reads high, as through a pull-up
            #3 sck = 1'b0;
        end
        #3 ce_n = 1'b1;
        si = ~si; // Released line must not keep the last bit
    endtask : xfer
    task automatic sel(input logic v);
        ce_n = ~v;
    endtask : sel
    // Two edges let the link side reset cleanly
    task automatic wake();
        repeat (2) begin
            #3 sck = 1'b1;
            #3 sck = 1'b0;
        end
    endtask : wake
endmodule : sfwe_spi_host

// File: testbench/sfwe_cmd_bench.sv
// Self-checking bench of the write/erase command block with a status model.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/1ns
`include "sfwe_defs.svh"
module sfwe_cmd_bench;
    import sfwe_pkg::*;
    localparam logic [7:0] SIG_N = 8'h3c; // Arbitrary identity value
    localparam logic [7:0] SIG_O = 8'h3d; // Arbitrary identity value
    localparam logic [7:0] SIG_L = 8'h3e; // Arbitrary identity value
    logic          mclk, rstn, sck, ce_n, si, wp_n, core_done, so_o, so_oe;
    logic          core_req, core_secure, secure_mode, secure_lock;
    sfwe_core_op_t core_op;
    logic [23:0]   core_addr, a;
    logic [15:0]   core_data, d;
    logic [7:0]    status, rd;
    logic          m_latch, m_busy, m_ai, m_lock;
    logic [2:0]    m_lvl;
    int            n_errors, cmp_count, seed, r;
    sfwe_cmd #(.SIG_NORMAL(SIG_N), .SIG_SECURE_OPEN(SIG_O), .SIG_SECURE_LOCK(SIG_L)) i_dut (
        .mclk(mclk), .rstn(rstn), .sck(sck), .ce_n(ce_n), .si(si), .so_o(so_o), .so_oe(so_oe),
        .wp_n(wp_n), .core_req(core_req), .core_op(core_op), .core_addr(core_addr),
        .core_data(core_data), .core_secure(core_secure), .core_done(core_done), .status(status),
        .secure_mode(secure_mode), .secure_lock(secure_lock));
    sfwe_spi_host i_host (.sck(sck), .ce_n(ce_n), .si(si), .so_o(so_o), .so_oe(so_oe));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    ////////////////////////////////////////
    function automatic logic [7:0] msr();
        return {m_lock, m_ai, 1'b0, m_lvl, m_latch, m_busy};
    endfunction : msr
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One frame, then watch for the core request it may launch
    task automatic run(input logic [63:0] b, input int n, input logic e, input logic [1:0] op,
                       input logic [23:0] ad);
        logic seen;
        seen = 1'b0;
        @(negedge mclk);
        i_host.xfer(b, n, rd);
        repeat (8) begin
            @(posedge mclk);
            #1;
            if (core_req === 1'b1) begin
                seen = 1'b1;
                chk("core_op", op, core_op);
                chk("core_addr", ad, core_addr);
                if (op == 2'd0) chk("core_data", d, core_data);
            end
        end
        chk("core_req", e, seen);
        if (seen) m_busy = 1'b1;
        chk("status", msr(), status);
    endtask : run
    task automatic read_status();
        run({`SFWE_OP_STATUS_READ, 8'h00}, 16, 0, 0, 0);
        chk("so_status", msr(), rd);
    endtask : read_status
    task automatic done();
        @(negedge mclk);
        core_done = 1'b1;
        @(negedge mclk);
        core_done = 1'b0;
        m_busy = 1'b0;
        if (!m_ai) m_latch = 1'b0;
        repeat (4) @(negedge mclk);
        chk("status", msr(), status);
    endtask : done
    task automatic probe(input logic e);
        @(negedge mclk);
        i_host.sel(1'b1);
        #1;
        chk("so_oe", 1, so_oe);
        chk("so_ready", e, so_o);
        i_host.sel(1'b0);
        repeat (5) @(negedge mclk);
    endtask : probe
    task automatic sig(input logic [7:0] e);
        run({`SFWE_OP_SIGNATURE, 32'h0}, 40, 0, 0, 0);
        chk("signature", e, rd);
    endtask : sig
    task automatic set_latch();
        m_latch = 1'b1;
        run(`SFWE_OP_LATCH_SET, 8, 0, 0, 0);
    endtask : set_latch
    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    initial begin
        #1_000_000;
        n_errors++;
        conclude();
    end
    initial begin
        seed = 5657;
        rstn = 1'b0;
        wp_n = 1'b1;
        core_done = 1'b0;
        d = 16'h0;
        {m_latch, m_busy, m_ai, m_lock, m_lvl} = '0;
        i_host.wake();
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        repeat (3) @(negedge mclk);
        read_status();
        run({`SFWE_OP_SECTOR_ERASE, 24'h001000}, 32, 0, 0, 0);
        for (int k = 0; k < 4; k++) begin
            set_latch();
            r = $random(seed);
            a = r[23:0] & 24'h0fffff;
            if (k == 0) run({`SFWE_OP_SECTOR_ERASE, a}, 32, 1, 1, a & 24'hfff000);
            if (k == 1) run({`SFWE_OP_BLOCK_ERASE, a}, 32, 1, 2, a & 24'hff0000);
            if (k > 1) run(k == 2 ? `SFWE_OP_CHIP_ERASE_A : `SFWE_OP_CHIP_ERASE_B, 8, 1, 3, 0);
            read_status();
            if (k == 0) sig(8'hff);
            done();
        end
        run(`SFWE_OP_STATUS_ARM, 8, 0, 0, 0);
        read_status();
        run({`SFWE_OP_STATUS_WRITE, 8'h9c}, 16, 0, 0, 0);
        run(`SFWE_OP_STATUS_ARM, 8, 0, 0, 0);
        {m_lock, m_lvl} = 4'hf;
        run({`SFWE_OP_STATUS_WRITE, 8'hff}, 16, 0, 0, 0);
        set_latch();
        run(`SFWE_OP_CHIP_ERASE_A, 8, 0, 0, 0);
        wp_n = 1'b0;
        set_latch();
        run({`SFWE_OP_STATUS_WRITE, 8'h00}, 16, 0, 0, 0);
        wp_n = 1'b1;
        set_latch();
        {m_lock, m_lvl, m_latch} = 5'h0;
        run({`SFWE_OP_STATUS_WRITE, 8'h00}, 16, 0, 0, 0);
        run(`SFWE_OP_BUSY_PIN_ON, 8, 0, 0, 0);
        set_latch();
        r = $random(seed);
        a = (r[23:0] & 24'h07fff0) | 24'h1;
        d = r[31:16];
        m_ai = 1'b1;
        run({`SFWE_OP_AUTOINC, a, d}, 48, 1, 0, a & 24'hfffffe);
        probe(1'b0);
        done();
        probe(1'b1);
        r = $random(seed);
        d = r[15:0];
        run({`SFWE_OP_AUTOINC, d}, 24, 1, 0, (a & 24'hfffffe) + 24'h2);
        done();
        {m_ai, m_latch} = 2'b00;
        run(`SFWE_OP_LATCH_CLEAR, 8, 0, 0, 0);
        run(`SFWE_OP_BUSY_PIN_OFF, 8, 0, 0, 0);
        set_latch();
        m_ai = 1'b1;
        run({`SFWE_OP_AUTOINC, 24'h0ffffe, d}, 48, 1, 0, 24'h0ffffe);
        read_status();
        m_ai = 1'b0;
        done();
        sig(SIG_N);
        run(`SFWE_OP_SECURE_ENTER, 8, 0, 0, 0);
        chk("secure_mode", 1, secure_mode);
        chk("core_secure", 1, core_secure);
        sig(SIG_O);
        run(`SFWE_OP_STATUS_ARM, 8, 0, 0, 0);
        run({`SFWE_OP_STATUS_WRITE, 8'h9c}, 16, 0, 0, 0);
        chk("secure_lock", 1, secure_lock);
        sig(SIG_L);
        set_latch();
        run({`SFWE_OP_AUTOINC, 24'h000000, d}, 48, 0, 0, 0);
        m_latch = 1'b0;
        run(`SFWE_OP_LATCH_CLEAR, 8, 0, 0, 0);
        chk("secure_mode", 0, secure_mode);
        conclude();
    end
endmodule : sfwe_cmd_bench
